//--- verilog/rtc_isa_decode_pkg.sv
// constants for the isa decode and clock port routing block
// assumes a pci configuration write port and an 8-bit i/o cycle port
package rtc_isa_decode_pkg;

  // configuration space offsets
  localparam logic [7:0] GEN_CFG_OFFSET   = 8'hb0;
  localparam logic [7:0] CLK_CFG_OFFSET   = 8'hcb;

  // reset values
  localparam logic [7:0] GEN_CFG_RESET    = 8'h00;
  localparam logic [7:0] CLK_CFG_RESET    = 8'h21;

  // general config fields
  localparam int         GEN_BUS_SEL_BIT  = 0;
  localparam int         GEN_DECODE_BIT   = 1;
  localparam logic [7:0] GEN_CFG_WMASK    = 8'h03;

  // clock port config fields
  localparam int         CLK_LOWER_EN_BIT = 0;
  localparam int         CLK_UPPER_EN_BIT = 2;
  localparam int         CLK_LOCK_LO_BIT  = 3;
  localparam int         CLK_LOCK_UP_BIT  = 4;
  localparam int         CLK_POS_DEC_BIT  = 5;
  localparam logic [7:0] CLK_CFG_WMASK    = 8'h25;

  // clock port addresses
  localparam logic [15:0] LOWER_INDEX_PORT = 16'h0070;
  localparam logic [15:0] LOWER_DATA_PORT  = 16'h0071;
  localparam logic [15:0] UPPER_INDEX_PORT = 16'h0072;
  localparam logic [15:0] UPPER_DATA_PORT  = 16'h0073;

  // locked byte range inside each bank
  localparam logic [6:0] LOCK_FIRST_BYTE  = 7'h38;
  localparam logic [6:0] LOCK_LAST_BYTE   = 7'h3f;

  // subtractive claim waits for medium/slow positive claims elsewhere
  localparam int         SUB_WAIT_NS      = 24;
  localparam int         CLK_PERIOD_NS    = 8;
  localparam logic [2:0] SUB_WAIT_CYCLES  = 3'(SUB_WAIT_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    DEC_IDLE,
    DEC_SUB_WAIT
  } decode_state_type;

endpackage

//--- verilog/rtc_isa_decode_config.sv
// decode style, expansion bus select and clock port routing with byte locks
// assumes io_req is a one-cycle pulse on the pci clock with address and data
// valid in the same cycle, and other_claim comes from same-clock pci logic
`timescale 1ns/100ps

module rtc_isa_decode_config
  import rtc_isa_decode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  input  wire logic        io_req,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        range_hit,
  input  wire logic        other_claim,
  output logic             claim_pos,
  output logic             claim_sub,
  output logic             fwd_isa,
  output logic             fwd_rtc,
  output logic             rtc_upper_bank,
  output logic             rtc_wr_en,
  output logic             rtc_rd_valid,
  output logic      [6:0]  rtc_index,
  output logic      [7:0]  rtc_wdata,
  output logic             extended_io_bus,
  input  wire logic        chk_pin_in,
  output logic             channel_check_in_n,
  output logic             general_input_zero,
  input  wire logic [6:0]  upper_latched_addr,
  input  wire logic [6:0]  general_outputs_low,
  output logic      [6:0]  shared_pin_out
);

  logic [7:0]       gen_cfg_reg;
  logic [7:0]       clk_cfg_reg;
  logic [6:0]       lower_index_reg;
  logic [6:0]       upper_index_reg;
  decode_state_type state_reg;
  logic [2:0]       wait_cnt_reg;
  logic             pend_rtc_reg;
  logic             pend_isa_reg;
  logic             pend_upper_reg;
  logic             pend_wr_reg;
  logic             pend_lock_reg;
  logic [6:0]       pend_index_reg;
  logic [7:0]       pend_wdata_reg;
  logic [2:0]       chk_sync_reg;
  logic             chk_state_reg;

  // request classification
  logic       is_lower_port;
  logic       is_upper_port;
  logic       is_clock_port;
  logic       is_data_port;
  logic       route_rtc;
  logic       want_pos;
  logic       want_sub;
  logic [6:0] cur_index;
  logic       cur_lock;

  assign is_lower_port = (io_addr == LOWER_INDEX_PORT) || (io_addr == LOWER_DATA_PORT);
  assign is_upper_port = (io_addr == UPPER_INDEX_PORT) || (io_addr == UPPER_DATA_PORT);
  assign is_clock_port = is_lower_port || is_upper_port;
  assign is_data_port  = (io_addr == LOWER_DATA_PORT) || (io_addr == UPPER_DATA_PORT);

  // internal bank reachable per port pair
  assign route_rtc = (is_lower_port && clk_cfg_reg[CLK_LOWER_EN_BIT])
                  || (is_upper_port && clk_cfg_reg[CLK_UPPER_EN_BIT]);

  // clock ports decode by bit 5, others by range and decode style
  always_comb begin
    if (is_clock_port) begin
      want_pos = clk_cfg_reg[CLK_POS_DEC_BIT];
      want_sub = !clk_cfg_reg[CLK_POS_DEC_BIT];
    end else begin
      want_pos = range_hit;
      want_sub = !range_hit && !gen_cfg_reg[GEN_DECODE_BIT];
    end
  end

  // lock check against the latched index of the addressed bank
  assign cur_index = is_upper_port ? upper_index_reg : lower_index_reg;
  assign cur_lock  = (cur_index >= LOCK_FIRST_BYTE) && (cur_index <= LOCK_LAST_BYTE)
                  && (is_upper_port ? clk_cfg_reg[CLK_LOCK_UP_BIT]
                                    : clk_cfg_reg[CLK_LOCK_LO_BIT]);

  // general config: decode style and bus select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gen_cfg_reg <= GEN_CFG_RESET;
    end else if (cfg_wr && cfg_addr == GEN_CFG_OFFSET) begin
      gen_cfg_reg <= cfg_wdata & GEN_CFG_WMASK;
    end
  end

  // clock config: lock bits only ever set until reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_cfg_reg <= CLK_CFG_RESET;
    end else if (cfg_wr && cfg_addr == CLK_CFG_OFFSET) begin
      clk_cfg_reg <= (cfg_wdata & CLK_CFG_WMASK) | (clk_cfg_reg & ~CLK_CFG_WMASK)
                   | (cfg_wdata & ((8'h01 << CLK_LOCK_LO_BIT) | (8'h01 << CLK_LOCK_UP_BIT)));
    end
  end

  // configuration read back, one cycle later
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_addr == GEN_CFG_OFFSET) begin
      cfg_rdata <= gen_cfg_reg;
    end else if (cfg_addr == CLK_CFG_OFFSET) begin
      cfg_rdata <= clk_cfg_reg;
    end else begin
      cfg_rdata <= 8'h00;
    end
  end

  // index ports latch the bank index on internal writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lower_index_reg <= 7'h00;
      upper_index_reg <= 7'h00;
    end else if (io_req && io_wr && route_rtc && state_reg == DEC_IDLE) begin
      if (io_addr == LOWER_INDEX_PORT) begin
        lower_index_reg <= io_wdata[6:0];
      end
      if (io_addr == UPPER_INDEX_PORT) begin
        upper_index_reg <= io_wdata[6:0];
      end
    end
  end

  // decode sequencer: positive at once, subtractive after the wait
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= DEC_IDLE;
      wait_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        DEC_IDLE: begin
          if (io_req && !want_pos && want_sub) begin
            state_reg    <= DEC_SUB_WAIT;
            wait_cnt_reg <= SUB_WAIT_CYCLES;
          end
        end
        DEC_SUB_WAIT: begin
          if (other_claim || wait_cnt_reg == 3'h1) begin
            state_reg <= DEC_IDLE;
          end
          wait_cnt_reg <= wait_cnt_reg - 3'h1;
        end
        default: begin
          state_reg <= DEC_IDLE;
        end
      endcase
    end
  end

  // hold the request details while a subtractive claim is pending
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_rtc_reg   <= 1'b0;
      pend_isa_reg   <= 1'b0;
      pend_upper_reg <= 1'b0;
      pend_wr_reg    <= 1'b0;
      pend_lock_reg  <= 1'b0;
      pend_index_reg <= 7'h00;
      pend_wdata_reg <= 8'h00;
    end else if (io_req && state_reg == DEC_IDLE) begin
      pend_rtc_reg   <= is_clock_port && route_rtc;
      pend_isa_reg   <= !(is_clock_port && route_rtc);
      pend_upper_reg <= is_upper_port;
      pend_wr_reg    <= io_wr;
      pend_lock_reg  <= is_data_port && cur_lock;
      pend_index_reg <= is_data_port ? cur_index : io_wdata[6:0];
      pend_wdata_reg <= io_wdata;
    end
  end

  // claim and forwarding pulses
  logic go_pos;
  logic go_sub;
  logic go_any;

  assign go_pos = io_req && state_reg == DEC_IDLE && want_pos;
  assign go_sub = state_reg == DEC_SUB_WAIT && !other_claim && wait_cnt_reg == 3'h1;
  assign go_any = go_pos || go_sub;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      claim_pos      <= 1'b0;
      claim_sub      <= 1'b0;
      fwd_isa        <= 1'b0;
      fwd_rtc        <= 1'b0;
      rtc_upper_bank <= 1'b0;
      rtc_wr_en      <= 1'b0;
      rtc_rd_valid   <= 1'b0;
      rtc_index      <= 7'h00;
      rtc_wdata      <= 8'h00;
    end else if (go_pos) begin
      claim_pos      <= 1'b1;
      claim_sub      <= 1'b0;
      fwd_isa        <= !(is_clock_port && route_rtc);
      fwd_rtc        <= is_clock_port && route_rtc;
      rtc_upper_bank <= is_upper_port;
      rtc_wr_en      <= is_clock_port && route_rtc && io_wr
                        && !(is_data_port && cur_lock);
      rtc_rd_valid   <= is_clock_port && route_rtc && !io_wr
                        && !(is_data_port && cur_lock);
      rtc_index      <= is_data_port ? cur_index : io_wdata[6:0];
      rtc_wdata      <= io_wdata;
    end else if (go_sub) begin
      claim_pos      <= 1'b0;
      claim_sub      <= 1'b1;
      fwd_isa        <= pend_isa_reg;
      fwd_rtc        <= pend_rtc_reg;
      rtc_upper_bank <= pend_upper_reg;
      rtc_wr_en      <= pend_rtc_reg && pend_wr_reg && !pend_lock_reg;
      rtc_rd_valid   <= pend_rtc_reg && !pend_wr_reg && !pend_lock_reg;
      rtc_index      <= pend_index_reg;
      rtc_wdata      <= pend_wdata_reg;
    end else begin
      claim_pos      <= 1'b0;
      claim_sub      <= 1'b0;
      fwd_isa        <= 1'b0;
      fwd_rtc        <= 1'b0;
      rtc_wr_en      <= 1'b0;
      rtc_rd_valid   <= 1'b0;
    end
  end

  // shared input pin, three stage synchroniser with agreement
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chk_sync_reg  <= 3'b111;
      chk_state_reg <= 1'b1;
    end else begin
      chk_sync_reg <= {chk_sync_reg[1:0], chk_pin_in};
      if (chk_sync_reg[1] == chk_sync_reg[2]) begin
        chk_state_reg <= chk_sync_reg[2];
      end
    end
  end

  // pin multiplexing by bus select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      extended_io_bus    <= 1'b1;
      channel_check_in_n <= 1'b1;
      general_input_zero <= 1'b0;
      shared_pin_out     <= 7'h00;
    end else begin
      extended_io_bus    <= !gen_cfg_reg[GEN_BUS_SEL_BIT];
      channel_check_in_n <= gen_cfg_reg[GEN_BUS_SEL_BIT] ? chk_state_reg : 1'b1;
      general_input_zero <= gen_cfg_reg[GEN_BUS_SEL_BIT] ? 1'b0 : chk_state_reg;
      shared_pin_out     <= gen_cfg_reg[GEN_BUS_SEL_BIT] ? upper_latched_addr
                                                         : general_outputs_low;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_lock_upper_sticky: assert property (
    clk_cfg_reg[CLK_LOCK_UP_BIT] |=> clk_cfg_reg[CLK_LOCK_UP_BIT])
    else $error("upper lock cleared without reset");
  a_lock_lower_sticky: assert property (
    $fell(clk_cfg_reg[CLK_LOCK_LO_BIT]) |-> 1'b0)
    else $error("lower lock cleared without reset");
  a_positive_no_sub: assert property (
    io_req && state_reg == DEC_IDLE && !is_clock_port && gen_cfg_reg[GEN_DECODE_BIT]
      && !range_hit |=> !claim_pos ##1 !claim_sub [*3])
    else $error("positive mode claimed an unmapped cycle");
  a_range_claim: assert property (
    io_req && state_reg == DEC_IDLE && !is_clock_port && range_hit
      |=> claim_pos && fwd_isa)
    else $error("enabled range not claimed next cycle");
  a_sub_claim: assert property (
    io_req && state_reg == DEC_IDLE && !is_clock_port && !range_hit
      && !gen_cfg_reg[GEN_DECODE_BIT] ##1 !other_claim [*3] |=> claim_sub && fwd_isa)
    else $error("unclaimed cycle not taken subtractively");
  a_clock_pos: assert property (
    io_req && state_reg == DEC_IDLE && is_clock_port && clk_cfg_reg[CLK_POS_DEC_BIT]
      |=> claim_pos)
    else $error("clock port not positively decoded");
  a_upper_route: assert property (
    io_req && state_reg == DEC_IDLE && is_upper_port && clk_cfg_reg[CLK_POS_DEC_BIT]
      |=> fwd_rtc == $past(clk_cfg_reg[CLK_UPPER_EN_BIT]) && rtc_upper_bank)
    else $error("upper ports routed against enable");
  a_lower_route: assert property (
    io_req && state_reg == DEC_IDLE && is_lower_port && clk_cfg_reg[CLK_POS_DEC_BIT]
      |=> fwd_isa != $past(clk_cfg_reg[CLK_LOWER_EN_BIT]))
    else $error("lower ports routed against enable");
  a_locked_write: assert property (
    io_req && state_reg == DEC_IDLE && want_pos && is_data_port
      && cur_index >= LOCK_FIRST_BYTE && cur_index <= LOCK_LAST_BYTE
      && (is_upper_port ? clk_cfg_reg[CLK_LOCK_UP_BIT] : clk_cfg_reg[CLK_LOCK_LO_BIT])
      |=> claim_pos && !rtc_wr_en && !rtc_rd_valid)
    else $error("write reached a locked byte");
  a_locked_sub: assert property (
    io_req && state_reg == DEC_IDLE && !want_pos && want_sub && is_data_port && cur_lock
      ##1 !other_claim [*3] |=> claim_sub && !rtc_wr_en && !rtc_rd_valid)
    else $error("subtractive access reached a locked byte");

  a_pin_mux: assert property (
    gen_cfg_reg[GEN_BUS_SEL_BIT] && $stable(upper_latched_addr)
      |=> shared_pin_out == $past(upper_latched_addr))
    else $error("shared pins not carrying latched address");

  c_sub_claim:  cover property (claim_sub && fwd_isa);
  c_rtc_write:  cover property (fwd_rtc && rtc_wr_en && rtc_upper_bank);
  c_lock_block: cover property (fwd_rtc && !rtc_wr_en && !rtc_rd_valid);
  c_lost_sub:   cover property (state_reg == DEC_SUB_WAIT && other_claim);

endmodule

//--- verif/pci_host_model.sv
// pci host model: config writes, config reads and i/o cycles
// assumes the block samples on the rising edge; this model drives on the falling edge
`timescale 1ns/100ps

module pci_host_model (
  input  wire logic        clk,
  input  wire logic [7:0]  cfg_rdata,
  output logic             cfg_wr,
  output logic      [7:0]  cfg_addr,
  output logic      [7:0]  cfg_wdata,
  output logic             io_req,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic      [7:0]  io_wdata,
  output logic             range_hit,
  output logic             other_claim
);
  // quiet bus from time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    io_req = 1'b0;
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    range_hit = 1'b0;
    other_claim = 1'b0;
  end

  // one-cycle config write; data inverted once released
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask

  // read-back lags the selected offset by a cycle
  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    repeat (2) @(negedge clk);
    d = cfg_rdata;
  endtask

  // one-cycle i/o request; other agent's claim stays up until hold_off
  task automatic io_cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                          input logic rh, input logic oc);
    @(negedge clk);
    io_req = 1'b1;
    io_addr = a;
    io_wr = w;
    io_wdata = d;
    range_hit = rh;
    other_claim = oc;
    @(negedge clk);
    io_req = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    range_hit = 1'b0;
  endtask

  // other agent withdraws its claim
  task automatic hold_off();
    other_claim = 1'b0;
  endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the decode and clock port routing block
// assumes the host model drives the config and i/o side; pins driven here
`timescale 1ns/100ps

module testbench
  import rtc_isa_decode_pkg::*;
;
  localparam logic [5:0] F_POS_ISA = 6'h28;
  localparam logic [5:0] F_SUB_ISA = 6'h18;
  localparam logic [5:0] F_RTC_WR  = 6'h26;
  localparam logic [5:0] F_RTC_RD  = 6'h25;
  localparam logic [5:0] F_LOCKED  = 6'h24;
  logic clk, resetn, cfg_wr, io_req, io_wr, range_hit, other_claim, chk_pin_in;
  logic claim_pos, claim_sub, fwd_isa, fwd_rtc, rtc_upper_bank, rtc_wr_en, rtc_rd_valid;
  logic extended_io_bus, channel_check_in_n, general_input_zero;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_wdata, rtc_wdata;
  logic [15:0] io_addr;
  logic [6:0]  rtc_index, upper_latched_addr, general_outputs_low, shared_pin_out;
  int          errors = 0;
  int          comparisons = 0;

  rtc_isa_decode_config u_dut (.clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_req(io_req), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .range_hit(range_hit), .other_claim(other_claim),
    .claim_pos(claim_pos), .claim_sub(claim_sub), .fwd_isa(fwd_isa), .fwd_rtc(fwd_rtc),
    .rtc_upper_bank(rtc_upper_bank), .rtc_wr_en(rtc_wr_en), .rtc_rd_valid(rtc_rd_valid),
    .rtc_index(rtc_index), .rtc_wdata(rtc_wdata), .extended_io_bus(extended_io_bus),
    .chk_pin_in(chk_pin_in), .channel_check_in_n(channel_check_in_n),
    .general_input_zero(general_input_zero), .upper_latched_addr(upper_latched_addr),
    .general_outputs_low(general_outputs_low), .shared_pin_out(shared_pin_out));
  pci_host_model u_host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .io_req(io_req), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .range_hit(range_hit), .other_claim(other_claim));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    comparisons++;
    if (seen !== expected) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.cfg_read(a, d);
    check(d, e);
  endtask

  // issue a cycle, find the claim cycle and the flags seen with it
  task automatic io_check(input logic [15:0] a, input logic w, input logic [7:0] d,
                          input logic rh, input logic oc, input int ec, input logic [5:0] ef);
    int         cyc;
    logic [5:0] f;
    cyc = 0;
    f = 6'h00;
    u_host.io_cycle(a, w, d, rh, oc);
    for (int i = 1; i <= 6; i++) begin
      if (cyc == 0 && (claim_pos | claim_sub) === 1'b1) begin
        cyc = i;
        f = {claim_pos, claim_sub, fwd_isa, fwd_rtc, rtc_wr_en, rtc_rd_valid};
      end
      if (i < 6) @(negedge clk);
    end
    u_host.hold_off();
    check(8'(cyc), 8'(ec));
    check({2'b00, f}, {2'b00, ef});
  endtask

  task automatic t_reset();
    reg_check(CLK_CFG_OFFSET, 8'h21);
    reg_check(GEN_CFG_OFFSET, 8'h00);
    reg_check(8'h40, 8'h00);
    check({7'h00, extended_io_bus}, 8'h01);
    u_host.cfg_write(GEN_CFG_OFFSET, 8'hff);
    reg_check(GEN_CFG_OFFSET, 8'h03);
    u_host.cfg_write(GEN_CFG_OFFSET, 8'h00);
  endtask

  task automatic t_pins();
    // pin mux is registered: let the last bus select write show
    @(negedge clk);
    check({channel_check_in_n, shared_pin_out}, 8'haa);
    check({7'h00, general_input_zero}, 8'h01);
    chk_pin_in = 1'b0;
    // three sync stages, agreement stage, output stage
    repeat (5) @(negedge clk);
    check({channel_check_in_n, shared_pin_out}, 8'haa);
    check({7'h00, general_input_zero}, 8'h00);
    u_host.cfg_write(GEN_CFG_OFFSET, 8'h01);
    repeat (4) @(negedge clk);
    check({7'h00, extended_io_bus}, 8'h00);
    check({channel_check_in_n, shared_pin_out}, 8'h55);
    check({7'h00, general_input_zero}, 8'h00);
    u_host.cfg_write(GEN_CFG_OFFSET, 8'h00);
    chk_pin_in = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_decode();
    u_host.cfg_write(GEN_CFG_OFFSET, 8'h02);
    io_check(16'h0300, 1'b1, 8'h5a, 1'b1, 1'b0, 1, F_POS_ISA);
    io_check(16'h0300, 1'b1, 8'h5a, 1'b0, 1'b0, 0, 6'h00);
    io_check(LOWER_INDEX_PORT, 1'b1, 8'h11, 1'b0, 1'b0, 1, F_RTC_WR);
    check({1'b0, rtc_index}, 8'h11);
    u_host.cfg_write(GEN_CFG_OFFSET, 8'h00);
    io_check(16'h0300, 1'b0, 8'h00, 1'b0, 1'b0, 4, F_SUB_ISA);
    io_check(16'h0300, 1'b0, 8'h00, 1'b0, 1'b1, 0, 6'h00);
    io_check(16'h0300, 1'b0, 8'h00, 1'b1, 1'b0, 1, F_POS_ISA);
  endtask

  task automatic t_route();
    io_check(LOWER_INDEX_PORT, 1'b1, 8'h05, 1'b0, 1'b0, 1, F_RTC_WR);
    check({7'h00, rtc_upper_bank}, 8'h00);
    io_check(UPPER_INDEX_PORT, 1'b1, 8'h06, 1'b0, 1'b0, 1, F_POS_ISA);
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h25);
    io_check(UPPER_INDEX_PORT, 1'b1, 8'h06, 1'b0, 1'b0, 1, F_RTC_WR);
    check({rtc_upper_bank, rtc_index}, 8'h86);
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h24);
    io_check(LOWER_INDEX_PORT, 1'b1, 8'h05, 1'b0, 1'b0, 1, F_POS_ISA);
    io_check(UPPER_DATA_PORT, 1'b0, 8'h00, 1'b0, 1'b0, 1, F_RTC_RD);
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h04);
    io_check(LOWER_DATA_PORT, 1'b0, 8'h00, 1'b0, 1'b0, 4, F_SUB_ISA);
    io_check(UPPER_DATA_PORT, 1'b1, 8'h77, 1'b0, 1'b0, 4, 6'h16);
    check(rtc_wdata, 8'h77);
    io_check(UPPER_DATA_PORT, 1'b1, 8'h77, 1'b0, 1'b1, 0, 6'h00);
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h25);
  endtask

  task automatic t_locks();
    u_host.cfg_write(CLK_CFG_OFFSET, 8'hff);
    reg_check(CLK_CFG_OFFSET, 8'h3d);
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h25);
    reg_check(CLK_CFG_OFFSET, 8'h3d);
    io_check(LOWER_INDEX_PORT, 1'b1, 8'h38, 1'b0, 1'b0, 1, F_RTC_WR);
    io_check(LOWER_DATA_PORT, 1'b1, 8'h99, 1'b0, 1'b0, 1, F_LOCKED);
    check({1'b0, rtc_index}, 8'h38);
    io_check(LOWER_INDEX_PORT, 1'b1, 8'h37, 1'b0, 1'b0, 1, F_RTC_WR);
    io_check(LOWER_DATA_PORT, 1'b0, 8'h00, 1'b0, 1'b0, 1, F_RTC_RD);
    io_check(UPPER_INDEX_PORT, 1'b1, 8'h3f, 1'b0, 1'b0, 1, F_RTC_WR);
    io_check(UPPER_DATA_PORT, 1'b0, 8'h00, 1'b0, 1'b0, 1, F_LOCKED);
    io_check(UPPER_INDEX_PORT, 1'b1, 8'h40, 1'b0, 1'b0, 1, F_RTC_WR);
    io_check(UPPER_DATA_PORT, 1'b1, 8'h12, 1'b0, 1'b0, 1, F_RTC_WR);
    // locks still hold on the subtractive path
    u_host.cfg_write(CLK_CFG_OFFSET, 8'h04);
    reg_check(CLK_CFG_OFFSET, 8'h1c);
    io_check(UPPER_INDEX_PORT, 1'b1, 8'h3a, 1'b0, 1'b0, 4, 6'h16);
    io_check(UPPER_DATA_PORT, 1'b1, 8'h12, 1'b0, 1'b0, 4, 6'h14);
    // only a hardware reset drops the locks
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    reg_check(CLK_CFG_OFFSET, 8'h21);
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    chk_pin_in = 1'b1;
    upper_latched_addr = 7'h55;
    general_outputs_low = 7'h2a;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_pins();
    t_decode();
    t_route();
    t_locks();
    wrap_up();
  end

  // hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
